/* File: dv/secp_eeprom_props.sv */
`timescale 1ns/100ps
module secp_eeprom_props #(
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic chip_select_strap_high,
  input wire logic chip_select_strap_low,
  input wire logic write_protect,
  input wire logic standby,
  input wire logic busy
);
  logic [16:0] cnt;
  // counts programming cycles so the length check needs no long repetition
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      cnt <= 17'h0;
    else
      cnt <= busy ? cnt + 17'h1 : 17'h0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_out_zero: assert property (sda_out == 1'b0) else $error("data pin value not zero");
  a_busy_quiet: assert property (busy |-> sda_oe_n) else $error("driven while programming");
  a_busy_idle: assert property (!(busy && standby)) else $error("standby while programming");
  a_reset_idle: assert property ($fell(rst) |-> standby && sda_oe_n && !busy) else $error("not idle after reset");
  a_prog_len: assert property ($fell(busy) |-> cnt == PROG_CYCLES) else $error("programming length wrong");
  a_prog_stop: assert property ($rose(busy) |-> scl && !write_protect) else $error("programming without stop");
  a_drive_low: assert property (scl && $past(scl) |-> $stable(sda_oe_n)) else $error("drive changed in high");
  a_standby_rel: assert property (standby |-> sda_oe_n) else $error("driven in standby");
  // catches a programming cycle that never ends, which a_prog_len alone would miss
  a_busy_max: assert property (busy |-> cnt < PROG_CYCLES) else $error("programming too long");
  a_prog_entry: assert property ($rose(busy) |-> !$past(standby)) else $error("programming from standby");
endmodule // secp_eeprom_props

bind secp_eeprom secp_eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (
  .clk_sys, .rst, .scl, .sda_in, .sda_out, .sda_oe_n, .chip_select_strap_high,
  .chip_select_strap_low, .write_protect, .standby, .busy
);

/* File: dv/secp_host.sv */
`timescale 1ns/100ps
module secp_host (
  input  wire logic clk_sys,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  logic [7:0] res_data;
  logic       res_ack;
  event       ack_ev;
  event       data_ev;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // data moves one cycle after the fall so it never looks like a start or stop
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda;
    scl <= 1'b0;
  endtask
  // extra low time lets a device acknowledge release before the start
  task automatic start();
    tick(1);
    sda_drv <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  task automatic put(input logic [7:0] b, input logic rep, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
    res_ack = ack;
    if (rep) -> ack_ev;
  endtask
  task automatic get(input logic host_ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      res_data[i] = r;
    end
    bit_io(host_ack, r);
    -> data_ev;
  endtask
endmodule // secp_host

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import secp_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       write_protect = 1'b0;
  logic       chip_select_strap_high = 1'b0;
  logic       chip_select_strap_low = 1'b0;
  wire        scl, sda_drv, sda_out, sda_oe_n, standby, busy;
  wire        sda = sda_drv & (sda_oe_n | sda_out);
  logic [7:0] mem [0:65535];
  logic       ack_q [$];
  logic [7:0] data_q [$];
  logic       flag_q [$];
  logic [7:0] dw;
  logic [1:0] cs;
  int         bad_count = 0;
  int         compares = 0;
  always #25 clk_sys = ~clk_sys;
  secp_host host_u (.clk_sys, .scl, .sda_drv, .sda);
  secp_eeprom #(.PROG_CYCLES(200)) dut_u (.clk_sys, .rst, .scl, .sda_in(sda), .sda_out, .sda_oe_n,
    .chip_select_strap_high, .chip_select_strap_low, .write_protect, .standby, .busy);
  task automatic close_out();
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check_ack(input logic got);
    logic e;
    e = ack_q.pop_front();
    compares++;
    if (got !== e) begin
      bad_count++;
      $display("[ERR] %0t ack got %h exp %h", $time, got, e);
    end
  endtask
  task automatic check_data(input logic [7:0] got);
    logic [7:0] e;
    e = data_q.pop_front();
    compares++;
    if (got !== e) begin
      bad_count++;
      $display("[ERR] %0t data got %h exp %h", $time, got, e);
    end
  endtask
  task automatic check_flag(input logic got);
    logic e;
    e = flag_q.pop_front();
    compares++;
    if (got !== e) begin
      bad_count++;
      $display("[ERR] %0t flag got %h exp %h", $time, got, e);
    end
  endtask
  always @(host_u.ack_ev) check_ack(host_u.res_ack);
  always @(host_u.data_ev) check_data(host_u.res_data);
  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    ack_q.push_back(exp);
    host_u.put(b, 1'b1, a);
  endtask
  task automatic addr(input logic [15:0] a);
    host_u.start();
    send(dw, 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], 1'b0);
  endtask
  task automatic write_seq(input logic [15:0] a, input int n);
    logic [7:0] d;
    addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      send(d, 1'b0);
      if (!write_protect) mem[{a[15:7], a[6:0] + 7'(i)}] = d;
    end
    host_u.stop();
  endtask
  // a protected write starts no programming, so its first poll is answered
  task automatic wait_ready(input logic exp_first);
    logic a;
    // the stop that ended the write was seen two edges ago, so busy has settled
    flag_q.push_back(exp_first);
    check_flag(busy);
    host_u.start();
    send(dw, exp_first);
    a = host_u.res_ack;
    for (int k = 0; k < 20 && a; k++) begin
      host_u.start();
      host_u.put(dw, 1'b0, a);
    end
    ack_q.push_back(1'b0);
    check_ack(a);
    host_u.stop();
  endtask
  task automatic read_seq(input logic [15:0] a, input int n, input logic cur);
    if (!cur) addr(a);
    host_u.start();
    send(dw | 8'h01, 1'b0);
    for (int i = 0; i < n; i++) begin
      data_q.push_back(mem[16'(a + 16'(i))]);
      host_u.get(i == n - 1);
    end
    host_u.stop();
  endtask
  initial begin
    void'($urandom(69977));
    cs = 2'($urandom);
    dw = {SECP_DEV_PREFIX, cs, 1'b0};
    @(posedge clk_sys);
    {chip_select_strap_high, chip_select_strap_low} <= cs;
    repeat (9) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    host_u.start();
    send({SECP_DEV_PREFIX, ~cs, 1'b0}, 1'b1);
    host_u.stop();
    write_seq(16'h0000, 1);
    wait_ready(1'b1);
    write_seq(16'hffc0, 130);
    wait_ready(1'b1);
    read_seq(16'hff80, 129, 1'b0);
    write_protect <= 1'b1;
    write_seq(16'hffff, 1);
    wait_ready(1'b0);
    write_protect <= 1'b0;
    read_seq(16'hff80, 1, 1'b1);
    read_seq(16'hffff, 1, 1'b0);
    repeat (20) @(posedge clk_sys);
    flag_q.push_back(1'b1);
    check_flag(standby);
    flag_q.push_back(1'b0);
    check_flag(busy);
    close_out();
  end
  // the sequence needs roughly twenty-one thousand cycles
  initial begin
    repeat (80000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end
endmodule // testbench

/* File: rtl/secp_eeprom.sv */
// How it works
// - address word follows every start condition
// - strap bits must match chip-select inputs
// - floating strap input reads as low (no pull-down in this logic; relies on the pad)
// - last address bit selects read or write
// - acknowledge on match, else back to standby
// - write-protect high blocks array writes of data bytes acknowledged while it is high
// - two address bytes, then data, each acknowledged
// - stop starts programming, inputs ignored meanwhile
// - page write takes up to 128 bytes
// - write address wraps within low seven bits
// - polling acknowledged only after programming ends
// - counter keeps last address plus one
// - read counter wraps from top to zero
// - current read sends byte at counter
// - host acknowledge continues read, nack and stop end
// - ninth clock carries acknowledge low
// - standby at reset, after a stop with no write pending, and when programming ends
`timescale 1ns/100ps
module secp_eeprom
  import secp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = SECP_PROG_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe_n,
  input  wire logic chip_select_strap_high,
  input  wire logic chip_select_strap_low,
  input  wire logic write_protect,
  output wire logic standby,
  output wire logic busy
);

  typedef struct packed {
    secp_state_t                st;
    logic [3:0]                 bitcnt;
    logic [7:0]                 shreg;
    logic [SECP_ADDR_W-1:0]     ctr;
    logic [7:0]                 addr_hi;
    logic                       is_read;
    logic                       drive;
    logic                       host_ack;
    logic                       pending;
    logic [SECP_PAGE_SIZE-1:0]  valid;
    logic [SECP_PROG_CNT_W-1:0] prog_cnt;
  } secp_core_t;

  localparam logic [SECP_PROG_CNT_W-1:0] PROG_LAST = SECP_PROG_CNT_W'(PROG_CYCLES - 1);
  localparam logic [SECP_PROG_CNT_W-1:0] PAGE_END  = SECP_PROG_CNT_W'(SECP_PAGE_SIZE);

  secp_link_if lk ();

  secp_link u_link (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .scl                    (scl),
    .sda_in                 (sda_in),
    .chip_select_strap_high (chip_select_strap_high),
    .chip_select_strap_low  (chip_select_strap_low),
    .write_protect          (write_protect),
    .lk                     (lk)
  );

  logic [7:0]                mem [SECP_MEM_WORDS];
  logic [7:0]                page_buf [SECP_PAGE_SIZE];
  logic [7:0]                rd_q;

  secp_core_t                r;
  secp_core_t                next_r;
  logic                      mem_we;
  logic [SECP_ADDR_W-1:0]    mem_addr;
  logic                      buf_we;
  logic [SECP_PAGE_BITS-1:0] buf_idx;
  logic                      load_rd;

  always_comb begin
    next_r   = r;
    mem_we   = 1'b0;
    mem_addr = {r.ctr[SECP_ADDR_W-1:SECP_PAGE_BITS], r.prog_cnt[SECP_PAGE_BITS-1:0]};
    buf_we   = 1'b0;
    buf_idx  = r.ctr[SECP_PAGE_BITS-1:0];
    load_rd  = 1'b0;
    if (r.st == SECP_PROG) begin
      // no start, stop or bit is looked at until the cycle ends
      next_r.prog_cnt = r.prog_cnt + 1'b1;
      // page commit in the first cycles; the upper counter bits still hold the page row
      if (r.prog_cnt < PAGE_END) begin
        mem_we = r.valid[r.prog_cnt[SECP_PAGE_BITS-1:0]];
      end
      if (r.prog_cnt == PROG_LAST) begin
        next_r.st      = SECP_IDLE;
        next_r.valid   = '0;
        next_r.pending = 1'b0;
      end
    end else if (lk.start_seen) begin
      // a repeated start drops any unfinished page write
      next_r.st      = SECP_DEV;
      next_r.bitcnt  = 4'h0;
      next_r.drive   = 1'b0;
      next_r.pending = 1'b0;
      next_r.valid   = '0;
    end else if (lk.stop_seen) begin
      next_r.drive  = 1'b0;
      next_r.bitcnt = 4'h0;
      if (r.pending) begin
        next_r.st       = SECP_PROG;
        next_r.prog_cnt = '0;
      end else begin
        next_r.st = SECP_IDLE;
      end
    end else begin
      case (r.st)
        SECP_DEV, SECP_AHI, SECP_ALO, SECP_WDAT: begin
          if (lk.scl_rise && r.bitcnt < SECP_BITS_PER_BYTE) begin
            next_r.shreg  = {r.shreg[6:0], lk.sda_bit};
            next_r.bitcnt = r.bitcnt + 1'b1;
          end
          if (lk.scl_fall && r.bitcnt == SECP_BITS_PER_BYTE) begin
            next_r.bitcnt = SECP_ACK_SLOT;
            next_r.drive  = 1'b1;
            case (r.st)
              SECP_DEV: begin
                if (r.shreg[SECP_DEV_PREFIX_HI:SECP_DEV_PREFIX_LO] == SECP_DEV_PREFIX &&
                    r.shreg[SECP_DEV_CS_HI_BIT] == lk.strap_hi &&
                    r.shreg[SECP_DEV_CS_LO_BIT] == lk.strap_lo) begin
                  next_r.is_read = r.shreg[SECP_DEV_DIR_BIT];
                end else begin
                  next_r.drive  = 1'b0;
                  next_r.bitcnt = 4'h0;
                  next_r.st     = SECP_IDLE;
                end
              end
              SECP_AHI: begin
                next_r.addr_hi = r.shreg;
              end
              SECP_ALO: begin
                next_r.ctr = {r.addr_hi, r.shreg};
              end
              default: begin
                // protected bytes are still acknowledged but never buffered
                if (!lk.wp_level) begin
                  buf_we                 = 1'b1;
                  next_r.pending         = 1'b1;
                  next_r.valid[buf_idx]  = 1'b1;
                end
                // low seven bits only, so the row is kept and bytes past 128 overwrite
                next_r.ctr[SECP_PAGE_BITS-1:0] = buf_idx + 1'b1;
              end
            endcase
          end
          if (lk.scl_fall && r.bitcnt == SECP_ACK_SLOT) begin
            next_r.drive  = 1'b0;
            next_r.bitcnt = 4'h0;
            case (r.st)
              SECP_DEV: begin
                if (r.is_read) begin
                  next_r.st = SECP_RD;
                  load_rd   = 1'b1;
                end else begin
                  next_r.st = SECP_AHI;
                end
              end
              SECP_AHI: next_r.st = SECP_ALO;
              default:  next_r.st = SECP_WDAT;
            endcase
          end
        end
        SECP_RD: begin
          if (lk.scl_rise && r.bitcnt == SECP_ACK_SLOT) begin
            next_r.host_ack = ~lk.sda_bit;
          end
          if (lk.scl_fall) begin
            if (r.bitcnt == SECP_ACK_SLOT) begin
              if (r.host_ack) begin
                load_rd = 1'b1;
              end else begin
                // no acknowledge: stay off the line and wait for the stop
                next_r.st     = SECP_IDLE;
                next_r.bitcnt = 4'h0;
                next_r.drive  = 1'b0;
              end
            end else if (r.bitcnt == SECP_BITS_PER_BYTE) begin
              next_r.drive  = 1'b0;
              next_r.bitcnt = SECP_ACK_SLOT;
            end else begin
              next_r.drive  = ~r.shreg[6];
              next_r.shreg  = {r.shreg[6:0], 1'b0};
              next_r.bitcnt = r.bitcnt + 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
      if (load_rd) begin
        // rd_q already follows the counter, which settled many cycles ago
        next_r.shreg    = rd_q;
        next_r.drive    = ~rd_q[7];
        next_r.bitcnt   = 4'h1;
        next_r.host_ack = 1'b0;
        next_r.ctr      = r.ctr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '{st: SECP_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // array and page buffer have no reset; contents live as long as power does
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_addr] <= page_buf[r.prog_cnt[SECP_PAGE_BITS-1:0]];
    end
    rd_q <= mem[r.ctr];
  end

  always_ff @(posedge clk_sys) begin
    if (buf_we) begin
      page_buf[buf_idx] <= r.shreg;
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~r.drive;
  assign standby  = (r.st == SECP_IDLE);
  assign busy     = (r.st == SECP_PROG);

endmodule // secp_eeprom

/* File: rtl/secp_link.sv */
`timescale 1ns/100ps
module secp_link (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda_in,
  input  wire logic chip_select_strap_high,
  input  wire logic chip_select_strap_low,
  input  wire logic write_protect,
  secp_link_if.link lk
);

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic cs_hi1;
    logic cs_hi2;
    logic cs_lo1;
    logic cs_lo2;
    logic wp1;
    logic wp2;
  } secp_link_state_t;

  secp_link_state_t r;
  secp_link_state_t next_r;

  // idle bus levels are high; straps and protect start low
  localparam secp_link_state_t SECP_LINK_RST = '{scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
                                                  sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
                                                  default: 1'b0};

  always_comb begin
    next_r        = r;
    next_r.scl1   = scl;
    next_r.scl2   = r.scl1;
    next_r.scl3   = r.scl2;
    next_r.sda1   = sda_in;
    next_r.sda2   = r.sda1;
    next_r.sda3   = r.sda2;
    next_r.cs_hi1 = chip_select_strap_high;
    next_r.cs_hi2 = r.cs_hi1;
    next_r.cs_lo1 = chip_select_strap_low;
    next_r.cs_lo2 = r.cs_lo1;
    next_r.wp1    = write_protect;
    next_r.wp2    = r.wp1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= SECP_LINK_RST;
    end else begin
      r <= next_r;
    end
  end

  // edges and conditions look only at second and third stages
  assign lk.scl_rise   = r.scl2 & ~r.scl3;
  assign lk.scl_fall   = ~r.scl2 & r.scl3;
  assign lk.sda_bit    = r.sda2;
  assign lk.start_seen = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign lk.stop_seen  = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  // a floating strap must be held low by the pad pull-down, so it reads as 0 here
  assign lk.strap_hi   = r.cs_hi2;
  assign lk.strap_lo   = r.cs_lo2;
  assign lk.wp_level   = r.wp2;

endmodule // secp_link

/* File: rtl/secp_link_if.sv */
`timescale 1ns/100ps
interface secp_link_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_bit;
  logic start_seen;
  logic stop_seen;
  logic strap_hi;
  logic strap_lo;
  logic wp_level;

  modport link (output scl_rise, scl_fall, sda_bit, start_seen, stop_seen, strap_hi, strap_lo, wp_level);
  modport core (input  scl_rise, scl_fall, sda_bit, start_seen, stop_seen, strap_hi, strap_lo, wp_level);
endinterface

/* File: rtl/secp_pkg.sv */
package secp_pkg;

  // byte framing on the two-wire link
  localparam logic [3:0] SECP_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] SECP_ACK_SLOT      = 4'h9;

  // device address word: fixed prefix, two strap bits, direction bit
  localparam logic [4:0] SECP_DEV_PREFIX    = 5'h14;
  localparam int         SECP_DEV_PREFIX_HI = 7;
  localparam int         SECP_DEV_PREFIX_LO = 3;
  localparam int         SECP_DEV_CS_HI_BIT = 2;
  localparam int         SECP_DEV_CS_LO_BIT = 1;
  localparam int         SECP_DEV_DIR_BIT   = 0;

  // array and page geometry
  localparam int SECP_ADDR_W    = 16;
  localparam int SECP_MEM_WORDS = 65536;
  localparam int SECP_PAGE_BITS = 7;
  localparam int SECP_PAGE_SIZE = 128;

  // programming cycle time in ms, and its length in clk_sys cycles
  localparam int SECP_CLK_HZ                 = 20000000;
  localparam int SECP_PROGRAMMING_CYCLE_TIME = 5;
  localparam int SECP_PROG_CYCLES            = SECP_PROGRAMMING_CYCLE_TIME * (SECP_CLK_HZ / 1000);
  localparam int SECP_PROG_CNT_W             = 17;

  typedef enum logic [2:0] {
    SECP_IDLE = 3'b000,
    SECP_DEV  = 3'b001,
    SECP_AHI  = 3'b010,
    SECP_ALO  = 3'b011,
    SECP_WDAT = 3'b100,
    SECP_RD   = 3'b101,
    SECP_PROG = 3'b110
  } secp_state_t;

endpackage
